// ===== logic/pus_pkg.sv
// Constants for the power-up defaults and address strap block.
// Assumes a 25 MHz system clock and an AXI4-Lite register port.
// Summary of operation
// - Decode two three-level straps into nine addresses.
// - Sample straps at power-up, latch target address.
// - Autoconvert after power-up: 4 Hz, channel one 8 Hz.
// - Command pointer powers up at zero.
// - Limits load default maximum and minimum values.
// - Hysteresis powers up at ten degrees.
// - Straps sampled only at power-on or reset.
// - External reset restores defaults and resamples straps.
// - Conversion-rate register powers up at fastest value.
package pus_pkg;
   // =========================================================
   // Strap levels and address table
   typedef enum logic [1:0] {PUS_LVL_GND, PUS_LVL_OPEN, PUS_LVL_VCC} pus_lvl_e;
   localparam logic [3:0] PUS_GRP_GND   = 4'h3;
   localparam logic [3:0] PUS_GRP_OPEN  = 4'h5;
   localparam logic [3:0] PUS_GRP_VCC   = 4'h9;
   localparam logic [2:0] PUS_LOW_GND_GND = 3'h0;
   localparam logic [2:0] PUS_LOW_OPEN_GND = 3'h1;
   localparam logic [2:0] PUS_LOW_VCC_GND = 3'h4;
   // =========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] PUS_OFF_CTRL  = 8'h00;
   localparam logic [7:0] PUS_OFF_STAT  = 8'h04;
   localparam logic [7:0] PUS_OFF_RATE  = 8'h08;
   localparam logic [7:0] PUS_OFF_CMD   = 8'h0C;
   localparam logic [7:0] PUS_OFF_HIGH  = 8'h10;
   localparam logic [7:0] PUS_OFF_LOW   = 8'h14;
   localparam logic [7:0] PUS_OFF_HYST  = 8'h18;
   localparam logic [7:0] PUS_OFF_CNT   = 8'h1C;
   // =========================================================
   // Reset values
   localparam logic [2:0] PUS_RATE_POR  = 3'h6;
   localparam logic [7:0] PUS_CMD_POR   = 8'h00;
   localparam logic [7:0] PUS_HIGH_POR  = 8'h7F;
   localparam logic [7:0] PUS_LOW_POR   = 8'hC9;
   localparam logic [7:0] PUS_HYST_POR  = 8'h0A;
   localparam logic [1:0] PUS_RESP_OK   = 2'h0;
   localparam logic [1:0] PUS_RESP_ERR  = 2'h2;
   // =========================================================
   // Timing
   localparam int PUS_CLK_HZ     = 25000000;
   localparam int PUS_FAST_HZ    = 8;
   localparam int PUS_FAST_TICKS = PUS_CLK_HZ / PUS_FAST_HZ;
   localparam int PUS_SETTLE     = 4;
   // =========================================================
   // Address decode
   function automatic logic [6:0] pus_decode(input pus_lvl_e a, input pus_lvl_e b);
      logic [3:0] grp;
      logic [2:0] low;
      grp = (a == PUS_LVL_GND) ? PUS_GRP_GND : (a == PUS_LVL_OPEN) ? PUS_GRP_OPEN : PUS_GRP_VCC;
      low = (a == PUS_LVL_GND) ? PUS_LOW_GND_GND :
            (a == PUS_LVL_OPEN) ? PUS_LOW_OPEN_GND : PUS_LOW_VCC_GND;
      low = low + ((b == PUS_LVL_GND) ? 3'h0 : (b == PUS_LVL_OPEN) ? 3'h1 : 3'h2);
      return {grp, low};
   endfunction
endpackage

// ===== logic/pus_strap.sv
// Three-level strap sensing for one pin.
// Assumes the pad gives a weak-pull-high and weak-pull-low reading.
`timescale 1ns/100ps
`default_nettype none
module pus_strap
   import pus_pkg::*;
(
   // Clock and reset
   input  wire logic     sys_clk,
   input  wire logic     rst,
   input  wire logic     clk_en,
   // Pad readings under pull-up and pull-down
   input  wire logic     pu_in,
   input  wire logic     pd_in,
   // Decoded level
   output var pus_lvl_e  level
);
   logic [1:0] sync1_q, sync1_d, sync2_q, sync2_d;

   always_comb begin
      sync1_d = {pu_in, pd_in};
      sync2_d = sync1_q;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else if (clk_en) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   // A floating pin follows the pull, so pull-up high and pull-down low.
   always_comb begin
      if (sync2_q == 2'h3)
         level = PUS_LVL_VCC;
      else if (sync2_q == 2'h2)
         level = PUS_LVL_OPEN;
      else
         level = PUS_LVL_GND;
   end
endmodule
`default_nettype wire

// ===== logic/pus_top.sv
// Power-up defaults, strap address latch and conversion scheduler.
// Assumes AXI4-Lite master on sys_clk; rst covers power-on and the reset pin.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module pus_top
   import pus_pkg::*;
#(
   parameter int FAST_TICKS = PUS_FAST_TICKS
)(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   // Strap pads
   input  wire logic        addr_strap_a_pu,
   input  wire logic        addr_strap_a_pd,
   input  wire logic        addr_strap_b_pu,
   input  wire logic        addr_strap_b_pd,
   // Results
   output logic [6:0]       target_addr,
   output logic             addr_valid,
   output logic             conv_ch1,
   output logic             conv_ch2_local,
   // AXI4-Lite
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // =========================================================
   // Strap sensing
   pus_lvl_e lvl_a, lvl_b;
   pus_strap u_strap_a (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
                        .pu_in(addr_strap_a_pu), .pd_in(addr_strap_a_pd), .level(lvl_a));
   pus_strap u_strap_b (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
                        .pu_in(addr_strap_b_pu), .pd_in(addr_strap_b_pd), .level(lvl_b));

   // =========================================================
   // Address latch: waits for the synchronisers to fill, then locks.
   logic [2:0] settle_q, settle_d;
   logic [6:0] addr_q, addr_d;
   logic       valid_q, valid_d;

   always_comb begin
      settle_d = settle_q;
      addr_d   = addr_q;
      valid_d  = valid_q;
      if (!valid_q) begin
         if (settle_q == 3'(PUS_SETTLE)) begin
            addr_d  = pus_decode(lvl_a, lvl_b);
            valid_d = 1'b1;
         end else
            settle_d = settle_q + 3'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         settle_q <= 3'h0;
         addr_q   <= 7'h00;
         valid_q  <= 1'b0;
      end else if (clk_en) begin
         settle_q <= settle_d;
         addr_q   <= addr_d;
         valid_q  <= valid_d;
      end
   end
   assign target_addr = addr_q;
   assign addr_valid  = valid_q;

   // =========================================================
   // Registers
   logic       run_q, run_d;
   logic [2:0] rate_q, rate_d;
   logic [7:0] cmd_q, cmd_d, high_q, high_d, low_q, low_d, hyst_q, hyst_d;

   // =========================================================
   // Conversion scheduler: channel one every tick, others every other tick.
   // Slower rate codes stretch the period by a power of two.
   logic [31:0] tick_q, tick_d;
   logic [7:0]  div_q, div_d;
   logic        c1_q, c1_d, c2_q, c2_d;
   logic [31:0] conv_cnt_q, conv_cnt_d;
   logic [2:0]  shift;

   always_comb begin
      shift      = (rate_q >= PUS_RATE_POR) ? 3'h0 : 3'(PUS_RATE_POR - rate_q);
      tick_d     = tick_q;
      div_d      = div_q;
      c1_d       = 1'b0;
      c2_d       = 1'b0;
      conv_cnt_d = conv_cnt_q;
      if (run_q && valid_q) begin
         if (tick_q >= 32'(FAST_TICKS - 1)) begin
            tick_d = 32'h0;
            div_d  = div_q + 8'h1;
            if ((div_q & ((8'h1 << shift) - 8'h1)) == 8'h0) begin
               c1_d       = 1'b1;
               c2_d       = div_q[shift];
               conv_cnt_d = conv_cnt_q + 32'h1;
            end
         end else
            tick_d = tick_q + 32'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tick_q     <= 32'h0;
         div_q      <= 8'h0;
         c1_q       <= 1'b0;
         c2_q       <= 1'b0;
         conv_cnt_q <= 32'h0;
      end else if (clk_en) begin
         tick_q     <= tick_d;
         div_q      <= div_d;
         c1_q       <= c1_d;
         c2_q       <= c2_d;
         conv_cnt_q <= conv_cnt_d;
      end
   end
   assign conv_ch1       = c1_q;
   assign conv_ch2_local = c2_q;

   // =========================================================
   // AXI4-Lite slave: one write and one read in flight.
   logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
   // Ready flags are registered so that every bus output leaves a flip-flop.
   logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d;
   logic [31:0] wdat_q, wdat_d;
   logic [7:0]  awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0]  br_q, br_d, rr_q, rr_d;

   function automatic logic [7:0] pus_merge(input logic [7:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
      return st[0] ? wd[7:0] : old;
   endfunction

   always_comb begin
      awh_d = awh_q; awa_d = awa_q; wh_d = wh_q; wd_d = wd_q;
      bv_d = bv_q; br_d = br_q; rv_d = rv_q; rr_d = rr_q; rd_d = rd_q;
      arr_d = arr_q;
      run_d = run_q; rate_d = rate_q; cmd_d = cmd_q;
      high_d = high_q; low_d = low_q; hyst_d = hyst_q;
      if (s_axi_awvalid && !awh_q && !bv_q) begin
         awh_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wh_q && !bv_q) begin
         wh_d = 1'b1;
         wd_d = {s_axi_wdata[31:4], s_axi_wstrb};
      end
      if (awh_q && wh_q) begin
         awh_d = 1'b0;
         wh_d  = 1'b0;
         bv_d  = 1'b1;
         br_d  = PUS_RESP_OK;
         unique case (awa_q)
            PUS_OFF_CTRL: run_d  = wd_q[0] ? wdat_q[0] : run_q;
            PUS_OFF_RATE: rate_d = wd_q[0] ? wdat_q[2:0] : rate_q;
            PUS_OFF_CMD:  cmd_d  = pus_merge(cmd_q, wdat_q, wd_q[3:0]);
            PUS_OFF_HIGH: high_d = pus_merge(high_q, wdat_q, wd_q[3:0]);
            PUS_OFF_LOW:  low_d  = pus_merge(low_q, wdat_q, wd_q[3:0]);
            PUS_OFF_HYST: hyst_d = pus_merge(hyst_q, wdat_q, wd_q[3:0]);
            PUS_OFF_STAT, PUS_OFF_CNT: br_d = PUS_RESP_OK;
            default:      br_d   = PUS_RESP_ERR;
         endcase
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
      if (s_axi_arvalid && arr_q) begin
         arr_d = 1'b0;
         rv_d  = 1'b1;
         rr_d  = PUS_RESP_OK;
         unique case (s_axi_araddr)
            PUS_OFF_CTRL: rd_d = {31'h0, run_q};
            PUS_OFF_STAT: rd_d = {24'h0, valid_q, addr_q};
            PUS_OFF_RATE: rd_d = {29'h0, rate_q};
            PUS_OFF_CMD:  rd_d = {24'h0, cmd_q};
            PUS_OFF_HIGH: rd_d = {24'h0, high_q};
            PUS_OFF_LOW:  rd_d = {24'h0, low_q};
            PUS_OFF_HYST: rd_d = {24'h0, hyst_q};
            PUS_OFF_CNT:  rd_d = conv_cnt_q;
            default: begin
               rd_d = 32'h0;
               rr_d = PUS_RESP_ERR;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d  = 1'b0;
         arr_d = 1'b1;
      end
      awrdy_d = !awh_d && !bv_d;
      wrdy_d  = !wh_d && !bv_d;
   end

   // Full write data kept separately; wd_q keeps only the strobes low.
   always_comb wdat_d = (s_axi_wvalid && !wh_q && !bv_q) ? s_axi_wdata : wdat_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         awh_q <= 1'b0; awa_q <= 8'h00; wh_q <= 1'b0; wd_q <= 32'h0; wdat_q <= 32'h0;
         bv_q <= 1'b0; br_q <= PUS_RESP_OK; arr_q <= 1'b1; rv_q <= 1'b0;
         awrdy_q <= 1'b1; wrdy_q <= 1'b1;
         rr_q <= PUS_RESP_OK; rd_q <= 32'h0;
         run_q  <= 1'b1;
         rate_q <= PUS_RATE_POR;
         cmd_q  <= PUS_CMD_POR;
         high_q <= PUS_HIGH_POR;
         low_q  <= PUS_LOW_POR;
         hyst_q <= PUS_HYST_POR;
      end else if (clk_en) begin
         awh_q <= awh_d; awa_q <= awa_d; wh_q <= wh_d; wd_q <= wd_d; wdat_q <= wdat_d;
         bv_q <= bv_d; br_q <= br_d; arr_q <= arr_d; rv_q <= rv_d;
         awrdy_q <= awrdy_d; wrdy_q <= wrdy_d;
         rr_q <= rr_d; rd_q <= rd_d;
         run_q <= run_d; rate_q <= rate_d; cmd_q <= cmd_d;
         high_q <= high_d; low_q <= low_d; hyst_q <= hyst_d;
      end
   end

   assign s_axi_awready = awrdy_q;
   assign s_axi_wready  = wrdy_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = arr_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rresp   = rr_q;
   assign s_axi_rdata   = rd_q;
endmodule
`default_nettype wire

// ===== bench/pus_pad.sv
// Strap pad model: turns a three-level pin into pull readings.
// Assumes the pad senses under weak pull-up and pull-down.
`timescale 1ns/100ps
`default_nettype none
module pus_pad
   import pus_pkg::*;
(
   // Pin level and readings
   input  wire pus_lvl_e lvl,
   output logic          pu,
   output logic          pd
);
   assign pu = (lvl != PUS_LVL_GND);
   assign pd = (lvl == PUS_LVL_VCC);
endmodule
`default_nettype wire

// ===== bench/pus_chk_sva.sv
// Checker for the strap address latch and conversion start.
// Assumes a bind onto pus_top; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module pus_chk
   import pus_pkg::*;
#(
   parameter int FAST_TICKS = 20
)(
   // Watched ports
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic [6:0] target_addr,
   input wire logic       addr_valid,
   input wire logic       conv_ch1,
   input wire logic       conv_ch2_local
);
   localparam int LIM = 2 * FAST_TICKS + 8;
   int g1_q;
   int g1_d;
   int g2_q;
   int g2_d;
   // Gap counters start large so the first pulse after reset is legal.
   always_comb begin
      g1_d = conv_ch1 ? 0 : g1_q + 1;
      g2_d = conv_ch2_local ? 0 : g2_q + 1;
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         g1_q <= 32'h000F_FFFF;
         g2_q <= 32'h000F_FFFF;
      end else begin
         g1_q <= g1_d;
         g2_q <= g2_d;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_rel;
      $fell(rst);
   endsequence
   sequence s_latch;
      !addr_valid ##[1:8] addr_valid;
   endsequence
   AST_GRP: assert property (addr_valid |->
      (target_addr[6:3] == 4'h3 && target_addr[2:0] <= 3'h2) ||
      (target_addr[6:3] == 4'h5 && target_addr[2:0] inside {[3'h1:3'h3]}) ||
      (target_addr[6:3] == 4'h9 && target_addr[2:0] inside {[3'h4:3'h6]}))
      else $error("bad latched address");
   AST_REL: assert property (s_rel |-> s_latch)
      else $error("address not latched after release");
   AST_STAY: assert property (addr_valid |=> addr_valid)
      else $error("address valid dropped");
   AST_HOLD: assert property (addr_valid |=> $stable(target_addr))
      else $error("latched address changed");
   AST_RSTDEF: assert property (disable iff (1'b0) rst |->
      !addr_valid && !conv_ch1 && !conv_ch2_local && target_addr == 7'h00)
      else $error("outputs not cleared in reset");
   AST_PULSE: assert property (conv_ch1 |=> !conv_ch1)
      else $error("channel one start not a pulse");
   AST_GAP1: assert property (conv_ch1 |-> g1_q >= FAST_TICKS - 1)
      else $error("channel one starts too close");
   AST_GAP2: assert property (conv_ch2_local |-> g2_q >= 2 * FAST_TICKS - 1)
      else $error("channel two starts too close");
   AST_AUTO: assert property (s_rel |-> ##[1:LIM] conv_ch1)
      else $error("no conversion after release");
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Bench for the strap latch, register defaults and conversion start.
// Assumes pus_top with a short tick parameter and AXI4-Lite access.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pus_pkg::*;
   localparam int FT = 20;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b0;
   logic        clk_en = 1'b1;
   pus_lvl_e    lvl_a = PUS_LVL_GND;
   pus_lvl_e    lvl_b = PUS_LVL_GND;
   logic        addr_strap_a_pu, addr_strap_a_pd, addr_strap_b_pu, addr_strap_b_pd;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [6:0]  target_addr;
   logic        addr_valid, conv_ch1, conv_ch2_local, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int          error_cnt = 0;
   int          checks_done = 0;
   always #20 sys_clk = ~sys_clk;
   pus_pad u_pa (.lvl(lvl_a), .pu(addr_strap_a_pu), .pd(addr_strap_a_pd));
   pus_pad u_pb (.lvl(lvl_b), .pu(addr_strap_b_pu), .pd(addr_strap_b_pd));
   pus_top #(.FAST_TICKS(FT)) u_dut (.sys_clk, .rst, .clk_en, .addr_strap_a_pu,
      .addr_strap_a_pd, .addr_strap_b_pu, .addr_strap_b_pd, .target_addr, .addr_valid,
      .conv_ch1, .conv_ch2_local, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // ==============================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
      if (er == PUS_RESP_OK) chk(s_axi_rdata, e, "rdata");
      s_axi_rready <= 1'b0;
   endtask
   task automatic do_rst(input int n);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (n) @(posedge sys_clk);
      rst <= 1'b0;
      for (int k = 0; k < 30 && addr_valid !== 1'b1; k++) @(posedge sys_clk);
   endtask
   task automatic rd_defaults();
      rd(PUS_OFF_RATE, 32'h6, PUS_RESP_OK);
      rd(PUS_OFF_CMD, 32'h0, PUS_RESP_OK);
      rd(PUS_OFF_HIGH, {24'h0, PUS_HIGH_POR}, PUS_RESP_OK);
      rd(PUS_OFF_LOW, {24'h0, PUS_LOW_POR}, PUS_RESP_OK);
      rd(PUS_OFF_HYST, 32'hA, PUS_RESP_OK);
   endtask
   // Address table: group by first strap, low bits from first plus second.
   function automatic logic [31:0] exp_addr(input int ia, input int ib);
      logic [3:0] g[3] = '{4'h3, 4'h5, 4'h9};
      logic [2:0] b[3] = '{3'h0, 3'h1, 3'h4};
      return {25'h0, g[ia], 3'(b[ia] + 3'(ib))};
   endfunction
   // ==============================================
   // Tests
   initial begin
      int n1;
      int n2;
      // A real edge on rst at time zero, so the flops start from reset.
      rst <= 1'b1;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         lvl_a <= pus_lvl_e'(i / 3);
         lvl_b <= pus_lvl_e'(i % 3);
         do_rst(2);
         chk({31'h0, addr_valid}, 32'h1, "valid");
         chk({25'h0, target_addr}, exp_addr(i / 3, i % 3), "addr");
         lvl_a <= pus_lvl_e'((i + 1) % 3);
         lvl_b <= pus_lvl_e'((i + 2) % 3);
         repeat (12) @(posedge sys_clk);
         chk({25'h0, target_addr}, exp_addr(i / 3, i % 3), "hold");
      end
      rd(PUS_OFF_STAT, 32'h80 | exp_addr(2, 2), PUS_RESP_OK);
      rd_defaults();
      wr(PUS_OFF_CMD, 32'h55, PUS_RESP_OK);
      wr(PUS_OFF_HYST, 32'h03, PUS_RESP_OK);
      wr(PUS_OFF_RATE, 32'h02, PUS_RESP_OK);
      wr(PUS_OFF_LOW, 32'h12, PUS_RESP_OK);
      rd(PUS_OFF_CMD, 32'h55, PUS_RESP_OK);
      rd(PUS_OFF_HYST, 32'h03, PUS_RESP_OK);
      rd(PUS_OFF_RATE, 32'h02, PUS_RESP_OK);
      rd(PUS_OFF_LOW, 32'h12, PUS_RESP_OK);
      wr(8'h40, 32'h11, PUS_RESP_ERR);
      rd(8'h40, 32'h0, PUS_RESP_ERR);
      do_rst(3);
      rd_defaults();
      n1 = 0;
      n2 = 0;
      repeat (10 * FT) begin
         @(posedge sys_clk);
         n1 += int'(conv_ch1);
         n2 += int'(conv_ch2_local);
      end
      chk(32'(n1), 32'hA, "ch1 count");
      chk(32'(n2), 32'h5, "ch2 count");
      rd(PUS_OFF_CNT, 32'hA, PUS_RESP_OK);
      // With the enable low the tick counter must not advance.
      clk_en <= 1'b0;
      n1 = 0;
      repeat (100) begin
         @(posedge sys_clk);
         n1 += int'(conv_ch1);
      end
      clk_en <= 1'b1;
      chk(32'(n1), 32'h0, "frozen ch1");
      rd(PUS_OFF_CNT, 32'hB, PUS_RESP_OK);
      wr(PUS_OFF_CTRL, 32'h0, PUS_RESP_OK);
      rd(PUS_OFF_CTRL, 32'h0, PUS_RESP_OK);
      n1 = 0;
      repeat (2 * FT) begin
         @(posedge sys_clk);
         n1 += int'(conv_ch1);
      end
      chk(32'(n1), 32'h0, "stopped ch1");
      rd(PUS_OFF_STAT, 32'h80 | exp_addr(0, 1), PUS_RESP_OK);
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("CHECK FAILED t=%0t watchdog expired", $time);
      finish_test();
   end
endmodule
bind pus_top pus_chk #(.FAST_TICKS(FAST_TICKS)) u_chk (.sys_clk, .rst, .target_addr,
   .addr_valid, .conv_ch1, .conv_ch2_local);
`default_nettype wire
